// ### design/pss_top.sv
// polygon scanner motor and laser line supervision
// assumes driver board returns ready on a pin; sync detector and laser
// current reports arrive on the laser driver's link clock
`default_nettype none
module pss_top
  import pss_pkg::*;
#(
  parameter logic [TMR_W-1:0] READY_LIMIT = TMR_W'(READY_LIMIT_CYC),
  parameter logic [TMR_W-1:0] SETTLE = TMR_W'(SETTLE_CYC),
  parameter logic [TMR_W-1:0] SYNC_GAP = TMR_W'(SYNC_GAP_CYC)
)
(
  input wire logic CLK_SYS, // system clock
  input wire logic SYS_RST, // async reset, active high
  input wire logic LINK_CLK, // laser driver link clock
  input wire logic MOTOR_ON, // firmware motor on request
  input wire logic [SPD_W-1:0] MOTOR_SPEED, // drive clock half period
  input wire logic LASER_ON, // firmware laser on request
  input wire logic FAULT_CLEAR, // pulse, clears all fault flags not set again in that cycle
  input wire logic SCANNER_SPEED_READY_N, // ready pin, low = at speed
  input wire logic LINE_SYNC_PULSE, // sync detector, link clock
  input wire logic CURRENT_VALID, // current report strobe, link clock
  input wire logic [CUR_W-1:0] LASER_OFFSET_CURRENT, // mA, link clock
  output logic SCANNER_MOTOR_RUN_CMD_N, // motor on command, low = on
  output logic SCANNER_MOTOR_DRIVE_CLOCK, // motor drive clock
  output logic LASER_ENABLE_COMMAND, // laser on command
  output logic MOTOR_RUNNING, // motor settled at speed and supervised; stays high after ready is lost
  output logic [NFLT-1:0] FAULT_FLAGS, // latched fault flags
  output logic [2:0] FAULT_CODE // code of lowest set flag, 0 if none
);
  if (READY_LIMIT <= SETTLE || SETTLE == '0 || SYNC_GAP == '0)
  begin : g_chk
    $error("pss_top: timing parameters out of range");
  end

  // ---------------- link domain ----------------
  // pulse and over-limit events leave the link domain as toggles; an event is
  // kept only if its toggle level holds for two system clock samples
  logic sync_prev_q;
  logic sync_tgl_q;
  logic oc_tgl_q;

  always_ff @(posedge LINK_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      sync_prev_q <= 1'b0;
      sync_tgl_q <= 1'b0;
    end
    else
    begin
      sync_prev_q <= LINE_SYNC_PULSE;
      if (LINE_SYNC_PULSE && !sync_prev_q)
        sync_tgl_q <= ~sync_tgl_q;
    end
  end

  always_ff @(posedge LINK_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      oc_tgl_q <= 1'b0;
    else if (CURRENT_VALID && LASER_OFFSET_CURRENT > CUR_LIMIT_MA)
      oc_tgl_q <= ~oc_tgl_q;
  end

  // ---------------- input synchronisers ----------------
  // bit 0 ready pin, bit 1 sync toggle, bit 2 overcurrent toggle
  localparam int NSYNC = 3;
  logic [NSYNC-1:0] sync_in;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  logic [NSYNC-1:0] s3_q;
  logic [NSYNC-1:0] filt_q;
  logic [NSYNC-1:0] filt_prev_q;

  assign sync_in = {oc_tgl_q, sync_tgl_q, SCANNER_SPEED_READY_N};

  for (genvar i = 0; i < NSYNC; i++)
  begin : g_sync
    // reset values match the idle levels so no false event at release
    localparam logic RST_V = (i == 0) ? 1'b1 : 1'b0;
    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
      if (SYS_RST)
      begin
        s1_q[i] <= RST_V;
        s2_q[i] <= RST_V;
        s3_q[i] <= RST_V;
        filt_q[i] <= RST_V;
        filt_prev_q[i] <= RST_V;
      end
      else
      begin
        s1_q[i] <= sync_in[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i])
          filt_q[i] <= s3_q[i];
        filt_prev_q[i] <= filt_q[i];
      end
    end
  end

  logic at_speed;
  logic ready_edge;
  logic sync_evt;
  logic oc_evt;
  assign at_speed = ~filt_q[0];
  assign ready_edge = filt_q[0] ^ filt_prev_q[0];
  assign sync_evt = filt_q[1] ^ filt_prev_q[1];
  assign oc_evt = filt_q[2] ^ filt_prev_q[2];

  // ---------------- motor command and drive clock ----------------
  logic [SPD_W-1:0] speed_q;
  logic on_q;
  logic speed_chg;
  logic turn_on;
  logic turn_off;

  assign speed_chg = on_q && MOTOR_ON && (MOTOR_SPEED != speed_q);
  assign turn_on = MOTOR_ON && !on_q;
  assign turn_off = !MOTOR_ON && on_q;

  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      on_q <= 1'b0;
      speed_q <= '0;
    end
    else
    begin
      on_q <= MOTOR_ON;
      speed_q <= MOTOR_SPEED;
    end
  end

  assign SCANNER_MOTOR_RUN_CMD_N = ~on_q;

  pss_drive_clk u_drive_clk (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .run(on_q),
    .half_period(speed_q),
    .drive_clk(SCANNER_MOTOR_DRIVE_CLOCK)
  );

  // ---------------- motor supervision ----------------
  pss_mot_e mot_q;
  logic [TMR_W-1:0] win_q;
  logic [TMR_W-1:0] stable_q;
  logic reached_q;
  logic want_ready;
  logic settled;
  logic win_end;

  assign want_ready = (mot_q == MOT_SPINUP);
  assign settled = (stable_q >= SETTLE) && (at_speed == want_ready);
  assign win_end = (win_q >= READY_LIMIT - 1'b1);

  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
      mot_q <= MOT_OFF;
    else if (turn_on || speed_chg)
      mot_q <= MOT_SPINUP;
    else if (turn_off)
      mot_q <= MOT_SPINDN;
    else
    begin
      case (mot_q)
        MOT_SPINUP:
          // a failed spin-up parks supervision so no ready-lost follows
          if (settled) mot_q <= MOT_RUN;
          else if (win_end) mot_q <= MOT_OFF;
        MOT_SPINDN: if (settled || win_end) mot_q <= MOT_OFF;
        default: mot_q <= mot_q;
      endcase
    end
  end

  // window timer and steady-level timer restart on every command
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      win_q <= '0;
      stable_q <= '0;
      reached_q <= 1'b0;
    end
    else if (turn_on || speed_chg || turn_off)
    begin
      win_q <= '0;
      stable_q <= '0;
      reached_q <= 1'b0;
    end
    else
    begin
      win_q <= win_end ? win_q : win_q + 1'b1;
      if (ready_edge)
        stable_q <= '0;
      else if (stable_q < SETTLE)
        stable_q <= stable_q + 1'b1;
      if (at_speed == want_ready)
        reached_q <= 1'b1;
    end
  end

  logic in_win;
  logic print_active;
  assign in_win = (mot_q == MOT_SPINUP) || (mot_q == MOT_SPINDN);
  assign MOTOR_RUNNING = (mot_q == MOT_RUN);

  // ---------------- laser and line sync ----------------
  logic laser_q;
  logic [TMR_W-1:0] gap_q;

  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
      laser_q <= 1'b0;
    else
      laser_q <= LASER_ON;
  end

  assign LASER_ENABLE_COMMAND = laser_q;
  assign print_active = laser_q && MOTOR_RUNNING && at_speed;

  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
      gap_q <= '0;
    else if (!print_active || sync_evt)
      gap_q <= '0;
    else if (gap_q < SYNC_GAP)
      gap_q <= gap_q + 1'b1;
  end

  // ---------------- fault flags ----------------
  logic [NFLT-1:0] flt_q;
  logic [NFLT-1:0] flt_set;
  logic timeout_now;

  assign timeout_now = in_win && win_end && !settled;

  always_comb
  begin
    flt_set = '0;
    // never reached the wanted level in the window
    flt_set[F_SPINUP] = timeout_now && want_ready && !reached_q;
    flt_set[F_SPINDN] = timeout_now && !want_ready
      && !reached_q;
    // reached it but kept chattering
    flt_set[F_UNSTABLE] = timeout_now && reached_q;
    flt_set[F_LOST] = MOTOR_RUNNING && !at_speed && !turn_off
      && !speed_chg;
    flt_set[F_SYNC] = print_active && (gap_q >= SYNC_GAP);
    flt_set[F_OVERCUR] = oc_evt;
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
      flt_q <= '0;
    else
      flt_q <= (FAULT_CLEAR ? '0 : flt_q) | flt_set;
  end

  function automatic logic [2:0] first_code(input logic [NFLT-1:0] f);
    logic [2:0] c;
    c = CODE_NONE;
    for (int k = NFLT - 1; k >= 0; k--)
      if (f[k])
        c = 3'(k + 1);
    return c;
  endfunction

  logic [2:0] code_q;
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
      code_q <= CODE_NONE;
    else
      code_q <= first_code(flt_q);
  end

  assign FAULT_FLAGS = flt_q;
  assign FAULT_CODE = code_q;
endmodule
`default_nettype wire

// ### design/pss_pkg.sv
// constants shared by the polygon scanner supervisor files
// assumes a 250 MHz system clock; link-side counts are not timed here
`default_nettype none
package pss_pkg;
  localparam longint unsigned SYS_CLK_HZ = 64'd250_000_000;
  // spin-up, spin-down and settle limit for the ready line, in seconds
  localparam longint unsigned READY_LIMIT_S = 64'd20;
  localparam longint unsigned READY_LIMIT_CYC = READY_LIMIT_S * SYS_CLK_HZ;
  // ready must hold its level this long to count as settled, in us
  localparam longint unsigned SETTLE_US = 64'd1000;
  localparam longint unsigned SETTLE_CYC = SETTLE_US * SYS_CLK_HZ
    / 64'd1_000_000;
  // longest gap between line-sync pulses while printing, in us
  localparam longint unsigned SYNC_GAP_US = 64'd2000;
  localparam longint unsigned SYNC_GAP_CYC = SYNC_GAP_US * SYS_CLK_HZ
    / 64'd1_000_000;
  localparam int TMR_W = 34;
  localparam int CUR_W = 8;
  // laser offset current limit, in mA (one code step per mA)
  localparam logic [7:0] CUR_LIMIT_MA = 8'h5A;
  localparam int SPD_W = 16;
  localparam int NFLT = 6;
  // fault flag positions
  localparam int F_SPINUP = 0;
  localparam int F_SPINDN = 1;
  localparam int F_LOST = 2;
  localparam int F_UNSTABLE = 3;
  localparam int F_SYNC = 4;
  localparam int F_OVERCUR = 5;
  localparam logic [2:0] CODE_NONE = 3'h0;
  typedef enum {MOT_OFF, MOT_SPINUP, MOT_RUN, MOT_SPINDN} pss_mot_e;
endpackage
`default_nettype wire

// ### design/pss_drive_clk.sv
// divider producing the polygon motor drive clock from the system clock
// assumes half_period is stable or changes only between motor commands
`default_nettype none
module pss_drive_clk
  import pss_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic run, // divider runs while high
  input wire logic [SPD_W-1:0] half_period, // half period in cycles
  output logic drive_clk // divided clock
);
  logic [SPD_W-1:0] cnt_q;
  logic clk_q;

  // a zero setting is treated as one so the clock never stalls high
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      clk_q <= 1'b0;
    end
    else if (!run)
    begin
      cnt_q <= '0;
      clk_q <= 1'b0;
    end
    else if (cnt_q + 1'b1 >= half_period)
    begin
      cnt_q <= '0;
      clk_q <= ~clk_q;
    end
    else
    begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign drive_clk = clk_q;
endmodule
`default_nettype wire

// ### verif/pss_chk.sv
// assertion checker on the scanner supervisor top ports
// assumes binding into pss_top; all checks use the system clock
`default_nettype none
module pss_chk
  import pss_pkg::*;
#(
  parameter logic [TMR_W-1:0] READY_LIMIT = TMR_W'(READY_LIMIT_CYC)
)
(
  input wire logic CLK_SYS, // clock
  input wire logic SYS_RST, // reset
  input wire logic MOTOR_ON, // motor request
  input wire logic [SPD_W-1:0] MOTOR_SPEED, // speed
  input wire logic LASER_ON, // laser request
  input wire logic FAULT_CLEAR, // clear
  input wire logic SCANNER_SPEED_READY_N, // ready pin
  input wire logic SCANNER_MOTOR_RUN_CMD_N, // motor cmd
  input wire logic SCANNER_MOTOR_DRIVE_CLOCK, // drive clock
  input wire logic LASER_ENABLE_COMMAND, // laser cmd
  input wire logic MOTOR_RUNNING, // at speed
  input wire logic [NFLT-1:0] FAULT_FLAGS, // flags
  input wire logic [2:0] FAULT_CODE // code
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);
  logic armed_q;
  logic [TMR_W-1:0] wait_q;
  logic [2:0] low_code;
  always_comb
  begin
    low_code = CODE_NONE;
    for (int i = NFLT - 1; i >= 0; i--)
      if (FAULT_FLAGS[i]) low_code = 3'(i + 1);
  end
  // armed only while the pin never reached the wanted level
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
    if (SYS_RST)
    begin
      armed_q <= 1'b0;
      wait_q <= '0;
    end
    else if ($changed(SCANNER_MOTOR_RUN_CMD_N) ||
      (!SCANNER_MOTOR_RUN_CMD_N && $changed(MOTOR_SPEED)))
    begin
      armed_q <= 1'b1;
      wait_q <= '0;
    end
    else
    begin
      if (SCANNER_SPEED_READY_N == SCANNER_MOTOR_RUN_CMD_N) armed_q <= 1'b0;
      wait_q <= wait_q + 1'b1;
    end
  sequence s_late;
    armed_q && wait_q == READY_LIMIT + 34'h000C && !FAULT_CLEAR;
  endsequence
  sequence s_lost;
    (MOTOR_RUNNING && SCANNER_SPEED_READY_N && !FAULT_CLEAR) [*8];
  endsequence
  a_cmd_follows: assert property (
    SCANNER_MOTOR_RUN_CMD_N == !$past(MOTOR_ON)) else $error("motor cmd");
  a_laser_follows: assert property (
    LASER_ENABLE_COMMAND == $past(LASER_ON)) else $error("laser cmd");
  a_clk_idle: assert property (
    SCANNER_MOTOR_RUN_CMD_N [*3] |-> !SCANNER_MOTOR_DRIVE_CLOCK)
    else $error("drive clock while off");
  a_lost_flag: assert property (
    s_lost |=> FAULT_FLAGS[F_LOST]) else $error("ready lost missed");
  a_code_lowest: assert property (
    FAULT_CODE == $past(low_code)) else $error("fault code");
  a_flags_sticky: assert property (!$past(FAULT_CLEAR) |->
    (FAULT_FLAGS & $past(FAULT_FLAGS)) == $past(FAULT_FLAGS))
    else $error("flag dropped");
  a_spinup_late: assert property (
    s_late ##0 !SCANNER_MOTOR_RUN_CMD_N |-> FAULT_FLAGS[F_SPINUP])
    else $error("spin-up fault missed");
  a_spindn_late: assert property (
    s_late ##0 SCANNER_MOTOR_RUN_CMD_N |-> FAULT_FLAGS[F_SPINDN])
    else $error("spin-down fault missed");
endmodule
bind pss_top pss_chk #(.READY_LIMIT(READY_LIMIT)) pss_chk_inst (.CLK_SYS,
  .SYS_RST, .MOTOR_ON, .MOTOR_SPEED, .LASER_ON, .FAULT_CLEAR,
  .SCANNER_SPEED_READY_N, .SCANNER_MOTOR_RUN_CMD_N,
  .SCANNER_MOTOR_DRIVE_CLOCK, .LASER_ENABLE_COMMAND, .MOTOR_RUNNING,
  .FAULT_FLAGS, .FAULT_CODE);
`default_nettype wire

// ### verif/pss_drv_model.sv
// motor driver board and sync detector model
// mode from bench: 0 good, 1 never ready, 2 chatter, 3 stuck low when off
`default_nettype none
module pss_drv_model
(
  input wire logic clk, // board clock
  input wire logic rst, // reset
  input wire logic run_cmd_n, // low = on
  input wire logic [1:0] mode, // behaviour
  input wire logic link_clk, // link clock
  input wire logic sync_on, // beam sweeps
  input wire logic laser_cmd, // laser on command from the block
  output logic ready_n, // low = at speed
  output logic sync_pulse // line sync
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cmd_q;
  logic [3:0] s_q;
  int t_q;
  logic laser_disable;
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      cmd_q <= 1'b1;
      t_q <= 0;
      ready_n <= 1'b1;
      laser_disable <= 1'b1;
    end
    else
    begin
      laser_disable <= !laser_cmd;
      cmd_q <= run_cmd_n;
      t_q <= (cmd_q != run_cmd_n) ? 0 : t_q + 1;
      if (!run_cmd_n)
        ready_n <= (mode == 2'h1) ? 1'b1 : (mode == 2'h2) ? t_q[3] :
          (t_q < 32'h0014);
      else
        ready_n <= (mode != 2'h3) && (ready_n || t_q >= 32'h0014);
    end
  always_ff @(posedge link_clk or posedge rst)
    if (rst)
    begin
      s_q <= 4'h0;
      sync_pulse <= 1'b0;
    end
    else
    begin
      s_q <= s_q + 4'h1;
      // the detector only sees a beam while the diodes fire
      sync_pulse <= sync_on && !laser_disable && (s_q == 4'h0);
    end
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// self-checking bench for the polygon scanner supervisor
// assumes the board model and bound checker beside the design
`default_nettype none
module tb_top
  import pss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, lclk = 0, rst = 1, on = 0, las = 0, clr = 0;
  logic vld = 0, sync_on = 0;
  logic [1:0] mode = 2'h0;
  logic [7:0] cur = 8'h00;
  logic [SPD_W-1:0] spd = 16'h0004;
  logic rdy_n, sync, cmd_n, dclk, lcmd, running, v;
  logic [NFLT-1:0] flags;
  logic [2:0] code;
  int bad_count = 0, n_compared = 0, e = 0, t, n;
  initial forever #2 clk = ~clk;
  initial
  begin
    #1.3;
    forever #6 lclk = ~lclk;
  end
  pss_top #(.READY_LIMIT(34'h07D0), .SETTLE(34'h0032),
    .SYNC_GAP(34'h00C8)) pss_top_inst (.CLK_SYS(clk), .SYS_RST(rst),
    .LINK_CLK(lclk), .MOTOR_ON(on), .MOTOR_SPEED(spd), .LASER_ON(las),
    .FAULT_CLEAR(clr), .SCANNER_SPEED_READY_N(rdy_n),
    .LINE_SYNC_PULSE(sync), .CURRENT_VALID(vld),
    .LASER_OFFSET_CURRENT(cur), .SCANNER_MOTOR_RUN_CMD_N(cmd_n),
    .SCANNER_MOTOR_DRIVE_CLOCK(dclk), .LASER_ENABLE_COMMAND(lcmd),
    .MOTOR_RUNNING(running), .FAULT_FLAGS(flags), .FAULT_CODE(code));
  pss_drv_model pss_drv_model_inst (.clk(clk), .rst(rst),
    .run_cmd_n(cmd_n), .mode(mode), .link_clk(lclk), .sync_on(sync_on),
    .laser_cmd(lcmd), .ready_n(rdy_n), .sync_pulse(sync));
  task automatic chk(string s, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s exp %h got %h", s, exp, seen);
    end
  endtask
  function automatic logic [2:0] lowc(int f);
    for (int i = 0; i < NFLT; i++)
      if (f[i]) return 3'(i + 1);
    return CODE_NONE;
  endfunction
  task automatic cyc(int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic fl(string s);
    cyc(2);
    chk("flags", 8'(flags), 8'(e));
    chk("code", 8'(code), 8'(lowc(e)));
    $display("test %s done", s);
  endtask
  task automatic clear();
    clr = 1;
    cyc(1);
    clr = 0;
    e = 0;
  endtask
  task automatic up();
    on = 1;
    for (t = 0; t < 400 && running !== 1'b1; t++)
      cyc(1);
    chk("running", 8'(running), 8'h01);
  endtask
  task automatic off();
    mode = 2'h0;
    las = 0;
    on = 0;
    cyc(100);
    clear();
  endtask
  task automatic send(logic [7:0] x);
    @(negedge lclk);
    vld = 1;
    cur = x;
    @(negedge lclk);
    vld = 0;
    cyc(20);
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #300us;
    bad_count++;
    summarize();
  end
  initial
  begin
    void'($urandom(60766));
    spd = 16'($urandom_range(9, 2));
    cyc(8);
    rst = 0;
    fl("reset");
    chk("cmd off", 8'(cmd_n), 8'h01);
    up();
    chk("cmd on", 8'(cmd_n), 8'h00);
    v = dclk;
    while (dclk === v) cyc(1);
    v = dclk;
    for (n = 0; dclk === v; n++) cyc(1);
    chk("half period", 8'(n), 8'(spd));
    mode = 2'h1;
    cyc(20);
    e = 1 << F_LOST;
    fl("ready lost");
    off();
    fl("cleared");
    mode = 2'h1;
    on = 1;
    cyc(1500);
    spd = 16'(spd + 1);
    cyc(1000);
    fl("window restart");
    cyc(1100);
    e = 1 << F_SPINUP;
    fl("spin-up fault");
    off();
    mode = 2'h2;
    on = 1;
    cyc(2100);
    e = 1 << F_UNSTABLE;
    fl("unstable");
    off();
    up();
    mode = 2'h3;
    on = 0;
    cyc(2100);
    e = 1 << F_SPINDN;
    fl("spin-down fault");
    off();
    up();
    las = 1;
    sync_on = 1;
    cyc(600);
    chk("laser cmd", 8'(lcmd), 8'h01);
    fl("sync present");
    sync_on = 0;
    cyc(300);
    e = 1 << F_SYNC;
    fl("sync lost");
    send(CUR_LIMIT_MA);
    fl("at limit");
    send(8'($urandom_range(255, 91)));
    e |= 1 << F_OVERCUR;
    fl("overcurrent");
    off();
    fl("final clear");
    summarize();
  end
endmodule
`default_nettype wire
